// ==== hw/cdl_line_io.sv ====
// The AXI4-Lite slave port and the placing of the registers were decided locally.
`timescale 1ns/1ns
`default_nettype none
// Operation
// - Four lines, picker selects, per-line settings
// - Direction makes line 1 or 2 input or output; lines 0 and 3 stay inputs
// - Polarity invert applied to line
// - Line level reports selected line state
// - All line levels vector, line n bit n
// - Filter kind select shared by all lines, per-line microsecond duration
// - Glitch filter accepts state after full width
// - Bounce filter passes first edge, then blocks
// - Glitch filter feeds bounce filter
// - Line driven only when direction is output
// - Output source choice mux
// - Soft output picker and level setting
// - All soft outputs vector, read and write
// - Read-only circuit type per line
// - Line 2 bidirectional with aux rail
// - Four soft output bits
module cdl_line_io
	import cdl_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire cdl_sources_t int_sources,
	input wire logic [NUM_LINES-1:0] line_in,
	output logic [NUM_LINES-1:0] line_out,
	output logic [NUM_LINES-1:0] line_oe,
	output logic aux_rail_switch,
	output logic [NUM_SOFT-1:0] soft_outputs
);

	// ****************************************
	// Fixed per-line circuit map
	// ****************************************
	// Line 0 opto in, 1 opto out, 2 open-drain GPIO, 3 plain input
	function automatic cdl_fmt_t line_fmt(input logic [1:0] n);
		unique case (n)
			2'h0: line_fmt = FMT_OPTO;
			2'h1: line_fmt = FMT_OPTO;
			2'h2: line_fmt = FMT_OPEN_DRAIN;
			default: line_fmt = FMT_TRI_STATE;
		endcase
	endfunction

	// Lines that may physically drive (isolated in line 0, line 3 input)
	function automatic logic can_drive(input logic [1:0] n);
		can_drive = (n == 2'h1) || (n == 2'h2);
	endfunction

	// Microseconds to cycles at the bus clock
	function automatic logic [WIDTH_W+4:0] us_to_cyc(input logic [15:0] us);
		us_to_cyc = (WIDTH_W+5)'(us) * (WIDTH_W+5)'(CLK_MHZ);
	endfunction

	// ****************************************
	// Register state
	// ****************************************
	logic [1:0] picker_q, picker_d;
	logic kind_q, kind_d;
	logic [1:0] soft_pick_q, soft_pick_d;
	logic [NUM_SOFT-1:0] soft_q, soft_d;
	cdl_line_cfg_t cfg_q [NUM_LINES];
	cdl_line_cfg_t cfg_d [NUM_LINES];
	logic [15:0] glitch_w_q [NUM_LINES];
	logic [15:0] glitch_w_d [NUM_LINES];
	logic [15:0] bounce_w_q [NUM_LINES];
	logic [15:0] bounce_w_d [NUM_LINES];
	logic aw_held_q, aw_held_d, w_held_q, w_held_d;
	logic [7:0] awaddr_q, awaddr_d;
	logic [31:0] wdata_q, wdata_d;
	logic bvalid_q, bvalid_d, rvalid_q, rvalid_d;
	logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
	logic [31:0] rdata_q, rdata_d;
	logic [NUM_LINES-1:0] level;
	logic [NUM_LINES-1:0] drive_val;

	// ****************************************
	// AXI4-Lite slave
	// ****************************************
	// Address and data are latched separately so either may come first
	assign s_axi_awready = !aw_held_q && !bvalid_q;
	assign s_axi_wready = !w_held_q && !bvalid_q;
	assign s_axi_arready = !rvalid_q;
	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp = bresp_q;
	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rresp = rresp_q;
	assign s_axi_rdata = rdata_q;

	// Next-state of all software-visible state
	always_comb begin
		logic [7:0] wa;
		logic [31:0] wd;
		logic do_wr;
		do_wr = 1'b0;
		wa = s_axi_awvalid && s_axi_awready ? s_axi_awaddr : awaddr_q;
		wd = s_axi_wvalid && s_axi_wready ? s_axi_wdata : wdata_q;
		aw_held_d = aw_held_q || (s_axi_awvalid && s_axi_awready);
		w_held_d = w_held_q || (s_axi_wvalid && s_axi_wready);
		awaddr_d = wa;
		wdata_d = wd;
		do_wr = aw_held_d && w_held_d && !bvalid_q;
		picker_d = picker_q;
		kind_d = kind_q;
		soft_pick_d = soft_pick_q;
		soft_d = soft_q;
		cfg_d = cfg_q;
		glitch_w_d = glitch_w_q;
		bounce_w_d = bounce_w_q;
		bvalid_d = bvalid_q && !s_axi_bready;
		bresp_d = bresp_q;
		if (do_wr) begin
			aw_held_d = 1'b0;
			w_held_d = 1'b0;
			bvalid_d = 1'b1;
			bresp_d = RESP_OKAY;
			unique case (wa[7:2])
				OFS_PICKER[7:2]: picker_d = wd[1:0];
				OFS_LINE_CFG[7:2]: begin
					cfg_d[picker_q].dir_out = wd[POS_DIR];
					cfg_d[picker_q].inv = wd[POS_INV];
					// Rail only exists on line 2
					cfg_d[picker_q].aux = wd[POS_AUX] && picker_q == 2'h2;
					cfg_d[picker_q].src = cdl_src_t'(wd[POS_SRC+:3]);
					cfg_d[picker_q].src_idx = wd[POS_SRCIDX+:2];
					kind_d = wd[POS_KIND];
				end
				OFS_FILTER[7:2]: begin
					if (kind_q)
						bounce_w_d[picker_q] = wd[15:0];
					else
						glitch_w_d[picker_q] = wd[15:0];
				end
				OFS_SOFT_PICK[7:2]: soft_pick_d = wd[1:0];
				OFS_SOFT_LEVEL[7:2]: soft_d[soft_pick_q] = wd[0];
				OFS_ALL_SOFT[7:2]: soft_d = wd[NUM_SOFT-1:0];
				OFS_LEVEL[7:2], OFS_ALL_LEVELS[7:2], OFS_FORMAT[7:2]: ;
				default: bresp_d = RESP_SLVERR;
			endcase
		end
		rvalid_d = rvalid_q && !s_axi_rready;
		rdata_d = rdata_q;
		rresp_d = rresp_q;
		if (s_axi_arvalid && s_axi_arready) begin
			rvalid_d = 1'b1;
			rresp_d = RESP_OKAY;
			rdata_d = 32'h0000_0000;
			unique case (s_axi_araddr[7:2])
				OFS_PICKER[7:2]: rdata_d[1:0] = picker_q;
				OFS_LINE_CFG[7:2]: begin
					rdata_d[POS_DIR] = cfg_q[picker_q].dir_out;
					rdata_d[POS_INV] = cfg_q[picker_q].inv;
					rdata_d[POS_AUX] = cfg_q[picker_q].aux;
					rdata_d[POS_SRC+:3] = cfg_q[picker_q].src;
					rdata_d[POS_SRCIDX+:2] = cfg_q[picker_q].src_idx;
					rdata_d[POS_KIND] = kind_q;
				end
				OFS_LEVEL[7:2]: rdata_d[0] = level[picker_q];
				OFS_ALL_LEVELS[7:2]: rdata_d[NUM_LINES-1:0] = level;
				OFS_FILTER[7:2]: rdata_d[15:0] = kind_q ?
					bounce_w_q[picker_q] : glitch_w_q[picker_q];
				OFS_SOFT_PICK[7:2]: rdata_d[1:0] = soft_pick_q;
				OFS_SOFT_LEVEL[7:2]: rdata_d[0] = soft_q[soft_pick_q];
				OFS_ALL_SOFT[7:2]: rdata_d[NUM_SOFT-1:0] = soft_q;
				OFS_FORMAT[7:2]: rdata_d[1:0] = line_fmt(picker_q);
				default: rresp_d = RESP_SLVERR;
			endcase
		end
	end

	// Register stage for the bus and settings
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			picker_q <= 2'h0;
			kind_q <= 1'b0;
			soft_pick_q <= 2'h0;
			soft_q <= RST_SOFT;
			for (int i = 0; i < NUM_LINES; i++) begin
				cfg_q[i] <= RST_CFG;
				glitch_w_q[i] <= RST_WIDTH;
				bounce_w_q[i] <= RST_WIDTH;
			end
			aw_held_q <= 1'b0;
			w_held_q <= 1'b0;
			awaddr_q <= 8'h00;
			wdata_q <= 32'h0000_0000;
			bvalid_q <= 1'b0;
			bresp_q <= RESP_OKAY;
			rvalid_q <= 1'b0;
			rresp_q <= RESP_OKAY;
			rdata_q <= 32'h0000_0000;
		end else begin
			picker_q <= picker_d;
			kind_q <= kind_d;
			soft_pick_q <= soft_pick_d;
			soft_q <= soft_d;
			cfg_q <= cfg_d;
			glitch_w_q <= glitch_w_d;
			bounce_w_q <= bounce_w_d;
			aw_held_q <= aw_held_d;
			w_held_q <= w_held_d;
			awaddr_q <= awaddr_d;
			wdata_q <= wdata_d;
			bvalid_q <= bvalid_d;
			bresp_q <= bresp_d;
			rvalid_q <= rvalid_d;
			rresp_q <= rresp_d;
			rdata_q <= rdata_d;
		end
	end

	assign soft_outputs = soft_q;
	assign aux_rail_switch = cfg_q[2].aux;

	// ****************************************
	// Per-line input path and output driver
	// ****************************************
	for (genvar g = 0; g < NUM_LINES; g++) begin : g_line
		logic sync1_q, sync2_q;
		logic gl_q, gl_d, bn_q, bn_d;
		logic [WIDTH_W+4:0] gcnt_q, gcnt_d, bcnt_q, bcnt_d;
		logic raw, drv;

		// Two-stage synchroniser; pins are asynchronous to aclk
		always_ff @(posedge aclk) begin
			if (!aresetn) begin
				sync1_q <= 1'b0;
				sync2_q <= 1'b0;
			end else begin
				sync1_q <= line_in[g];
				sync2_q <= sync1_q;
			end
		end

		// Driven lines read back what they drive, not the pin
		assign raw = line_oe[g] ? drive_val[g] : sync2_q;

		// Glitch then bounce filtering
		always_comb begin
			gl_d = gl_q;
			gcnt_d = '0;
			if (raw != gl_q) begin
				// Must hold the new state for the full width
				gcnt_d = gcnt_q + 1'b1;
				if (gcnt_d >= us_to_cyc(glitch_w_q[g])) begin
					gl_d = raw;
					gcnt_d = '0;
				end
			end
			bn_d = bn_q;
			bcnt_d = bcnt_q == '0 ? '0 : bcnt_q - 1'b1;
			// First edge passes at once, then a lockout
			if (bcnt_q == '0 && gl_q != bn_q) begin
				bn_d = gl_q;
				bcnt_d = us_to_cyc(bounce_w_q[g]);
			end
		end

		always_ff @(posedge aclk) begin
			if (!aresetn) begin
				gl_q <= 1'b0;
				bn_q <= 1'b0;
				gcnt_q <= '0;
				bcnt_q <= '0;
			end else begin
				gl_q <= gl_d;
				bn_q <= bn_d;
				gcnt_q <= gcnt_d;
				bcnt_q <= bcnt_d;
			end
		end

		// Level seen by software, after inversion
		assign level[g] = bn_q ^ cfg_q[g].inv;

		// Output source mux; loopback taps the filtered level
		always_comb begin
			logic s;
			s = 1'b0;
			unique case (cfg_q[g].src)
				SRC_LINE: s = level[cfg_q[g].src_idx];
				SRC_SOFT: s = soft_q[cfg_q[g].src_idx];
				SRC_COUNTER: s = int_sources.counter_active[cfg_q[g].src_idx[0]];
				SRC_LOGIC: s = int_sources.logic_block[cfg_q[g].src_idx[0]];
				SRC_EXPOSURE: s = int_sources.exposure_active;
				SRC_TRIG_WAIT: s = int_sources.trig_wait;
				default: s = 1'b0;
			endcase
			drv = s ^ cfg_q[g].inv;
		end

		// One driver per bit of the shared drive vector
		assign drive_val[g] = drv;

		// Drive only in output direction on a capable line
		assign line_oe[g] = cfg_q[g].dir_out && can_drive(2'(g));
		assign line_out[g] = drive_val[g];
	end

endmodule
`default_nettype wire

// ==== hw/cdl_pkg.sv ====
package cdl_pkg;

	// ****************************************
	// Sizes
	// ****************************************
	localparam int NUM_LINES = 4;
	localparam int NUM_SOFT = 4;
	localparam int WIDTH_W = 16;
	localparam int CLK_MHZ = 20;

	// ****************************************
	// Register byte offsets
	// ****************************************
	localparam logic [7:0] OFS_PICKER = 8'h00;
	localparam logic [7:0] OFS_LINE_CFG = 8'h04;
	localparam logic [7:0] OFS_LEVEL = 8'h08;
	localparam logic [7:0] OFS_ALL_LEVELS = 8'h0C;
	localparam logic [7:0] OFS_FILTER = 8'h10;
	localparam logic [7:0] OFS_SOFT_PICK = 8'h14;
	localparam logic [7:0] OFS_SOFT_LEVEL = 8'h18;
	localparam logic [7:0] OFS_ALL_SOFT = 8'h1C;
	localparam logic [7:0] OFS_FORMAT = 8'h20;

	// ****************************************
	// Line configuration field positions
	// ****************************************
	localparam int POS_DIR = 0;
	localparam int POS_INV = 1;
	localparam int POS_AUX = 2;
	localparam int POS_SRC = 4;
	localparam int POS_SRCIDX = 8;
	localparam int POS_KIND = 16;

	// ****************************************
	// Reset values
	// ****************************************
	localparam logic [15:0] RST_WIDTH = 16'h0000;
	localparam logic [3:0] RST_SOFT = 4'h0;

	// ****************************************
	// Responses
	// ****************************************
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Output source choices
	typedef enum logic [2:0] {
		SRC_LINE = 3'h0,
		SRC_SOFT = 3'h1,
		SRC_COUNTER = 3'h2,
		SRC_LOGIC = 3'h3,
		SRC_EXPOSURE = 3'h4,
		SRC_TRIG_WAIT = 3'h5
	} cdl_src_t;

	// Electrical circuit kinds, read only
	typedef enum logic [1:0] {
		FMT_TRI_STATE = 2'h0,
		FMT_OPTO = 2'h1,
		FMT_OPEN_DRAIN = 2'h2
	} cdl_fmt_t;

	// Per-line settings carried together
	typedef struct packed {
		logic [1:0] src_idx;
		cdl_src_t src;
		logic aux;
		logic inv;
		logic dir_out;
	} cdl_line_cfg_t;

	localparam cdl_line_cfg_t RST_CFG = '{2'h0, SRC_LINE, 1'b0, 1'b0, 1'b0};

	// Internal event signals fed to the output mux
	typedef struct packed {
		logic [1:0] counter_active;
		logic [1:0] logic_block;
		logic exposure_active;
		logic trig_wait;
	} cdl_sources_t;

endpackage

// ==== sim/cdl_ext_circuit.sv ====
`timescale 1ns/1ns
`default_nettype none
// ****
// Far-side circuits on the connector
// ****
module cdl_ext_circuit
	import cdl_pkg::*;
(
	input wire logic [NUM_LINES-1:0] line_out,
	input wire logic [NUM_LINES-1:0] line_oe,
	input wire logic [NUM_LINES-1:0] ext_drive,
	output logic [NUM_LINES-1:0] line_in
);
	// A driven line wins over the far side, so it reads back its drive
	assign line_in = (line_oe & line_out) | (~line_oe & ext_drive);
endmodule
`default_nettype wire

// ==== sim/cdl_line_io_checker.sv ====
`timescale 1ns/1ns
`default_nettype none
// ****
// Port checker
// ****
module cdl_line_io_checker
	import cdl_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [NUM_LINES-1:0] line_oe,
	input wire logic aux_rail_switch,
	input wire logic [NUM_SOFT-1:0] soft_outputs
);
	// One domain; reset masks every check
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	AST_OE_FIXED: assert property (!line_oe[0] && !line_oe[3])
		else $error("input-only line driven");
	AST_R_LAT: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready
		|=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped");
	AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("write answer dropped");
	AST_AR_BLOCK: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken while busy");
	AST_RST_VAL: assert property ($rose(aresetn) |-> line_oe == '0
		&& soft_outputs == '0 && !aux_rail_switch)
		else $error("outputs not cleared by reset");
	AST_SOFT_WR: assert property ($changed(soft_outputs) |-> s_axi_bvalid)
		else $error("soft outputs moved without a write");
	AST_OE_WR: assert property ($changed(line_oe) |-> s_axi_bvalid)
		else $error("drive enable moved without a write");
endmodule

bind cdl_line_io cdl_line_io_checker u_cdl_line_io_checker (.*);
`default_nettype wire

// ==== sim/tb_cdl_line_io.sv ====
`timescale 1ns/1ns
`default_nettype none
// ****
// Testbench
// ****
module tb_cdl_line_io
	import cdl_pkg::*;
;
	localparam cdl_fmt_t FMTS [4] = '{FMT_OPTO, FMT_OPTO, FMT_OPEN_DRAIN,
		FMT_TRI_STATE};
	logic aclk = '0;
	logic aresetn = '0;
	logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0;
	logic [31:0] s_axi_wdata = '0, s_axi_rdata, rdat;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic s_axi_awvalid = '0, s_axi_wvalid = '0, s_axi_bready = '0;
	logic s_axi_arvalid = '0, s_axi_rready = '0, v, rv;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic s_axi_rvalid, aux_rail_switch;
	logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
	cdl_sources_t int_sources = '0;
	logic [NUM_LINES-1:0] line_in, line_out, line_oe, ext = '0;
	logic [NUM_SOFT-1:0] soft_outputs;
	logic [2:0] hs;
	int err_total = 0, n_tests = 0, i;

	// Clock, 50 ns period
	initial forever #25 aclk = ~aclk;

	cdl_line_io u_cdl_line_io (.*);
	cdl_ext_circuit u_cdl_ext_circuit (.line_out(line_out),
		.line_oe(line_oe), .ext_drive(ext), .line_in(line_in));

	// One bus access; ready for the answer comes a cycle late on purpose
	task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		if (w) begin
			s_axi_awaddr <= a;
			s_axi_wdata <= d;
			s_axi_awvalid <= 1'h1;
			s_axi_wvalid <= 1'h1;
		end else begin
			s_axi_araddr <= a;
			s_axi_arvalid <= 1'h1;
		end
		do begin
			@(negedge aclk);
			n++;
			hs = {s_axi_awvalid & s_axi_awready, s_axi_wvalid & s_axi_wready,
				s_axi_arvalid & s_axi_arready};
			rv = w ? s_axi_bvalid : s_axi_rvalid;
			rsp = w ? s_axi_bresp : s_axi_rresp;
			rdat = s_axi_rdata;
			@(posedge aclk);
			if (hs[2])
				s_axi_awvalid <= '0;
			if (hs[1])
				s_axi_wvalid <= '0;
			if (hs[0])
				s_axi_arvalid <= '0;
			if (rv && w)
				s_axi_bready <= ~s_axi_bready;
			if (rv && !w)
				s_axi_rready <= ~s_axi_rready;
		end while (!(rv && (w ? s_axi_bready : s_axi_rready)) && n < 40);
		if (n >= 40)
			err_total++;
	endtask

	// Compare and count; x or z never matches
	task chk(input logic [31:0] seen, input logic [31:0] exp, input string nm);
		n_tests++;
		if (seen !== exp) begin
			err_total++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task rc(input logic [7:0] a, input logic [31:0] exp, input string nm);
		xfer(1'h0, a, '0);
		chk(rdat, exp, nm);
	endtask

	// Verdict; the only place the run ends
	task results();
		$display("Comparisons %0d mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// Watchdog: the run needs well under 2000 cycles
	initial begin
		#(50 * 6000);
		err_total++;
		results();
	end

	// ****
	// Test sequence
	// ****
	initial begin
		repeat (6) @(posedge aclk);
		aresetn <= 1'h1;
		@(posedge aclk);
		// Settings kept apart per line, circuit kinds fixed
		for (i = 0; i < 4; i++) begin
			xfer(1'h1, OFS_PICKER, i);
			rc(OFS_FORMAT, FMTS[i], "format");
			rc(OFS_LINE_CFG, 0, "cfg reset");
			xfer(1'h1, OFS_LINE_CFG, i << 8);
		end
		for (i = 0; i < 4; i++) begin
			xfer(1'h1, OFS_PICKER, i);
			rc(OFS_LINE_CFG, i << 8, "cfg");
		end
		xfer(1'h1, OFS_PICKER, 2);
		xfer(1'h1, OFS_LINE_CFG, 32'h4);
		chk(aux_rail_switch, 1, "aux");
		// Soft outputs, whole vector and single bit
		xfer(1'h1, OFS_ALL_SOFT, 32'hA);
		chk(soft_outputs, 4'hA, "soft");
		xfer(1'h1, OFS_SOFT_PICK, 2);
		xfer(1'h1, OFS_SOFT_LEVEL, 1);
		chk(soft_outputs, 4'hE, "soft");
		rc(OFS_SOFT_LEVEL, 1, "soft level");
		rc(OFS_ALL_SOFT, 32'hE, "all soft");
		// Unmapped place refused, read-only place ignores writes
		xfer(1'h1, 8'h30, 1);
		chk(rsp, RESP_SLVERR, "bresp");
		xfer(1'h0, 8'h30, 0);
		chk(rsp, RESP_SLVERR, "rresp");
		xfer(1'h1, OFS_ALL_LEVELS, 32'hF);
		chk(rsp, RESP_OKAY, "ro bresp");
		rc(OFS_ALL_LEVELS, 0, "levels");
		// Input levels, then inverted
		ext <= 4'h9;
		repeat (8) @(posedge aclk);
		rc(OFS_ALL_LEVELS, 9, "levels");
		xfer(1'h1, OFS_PICKER, 3);
		rc(OFS_LEVEL, 1, "level");
		xfer(1'h1, OFS_LINE_CFG, 32'h302);
		rc(OFS_LEVEL, 0, "inverted");
		// Every output source at both levels on line 1
		xfer(1'h1, OFS_PICKER, 1);
		for (i = 0; i < 12; i++) begin
			v = i[0];
			int_sources <= {6{v}};
			ext[0] <= v;
			xfer(1'h1, OFS_ALL_SOFT, {4{v}});
			xfer(1'h1, OFS_LINE_CFG, 32'h1 | (i >> 1) << 4);
			repeat (8) @(posedge aclk);
			chk(line_out[1], v, "out");
			chk(line_oe[1], 1, "oe");
		end
		xfer(1'h1, OFS_LINE_CFG, 32'h13);
		chk(line_out[1], 0, "out inverted");
		xfer(1'h1, OFS_LINE_CFG, 32'h10);
		chk(line_oe[1], 0, "oe");
		// Line 2 drives from soft output 0 and reads its drive back
		xfer(1'h1, OFS_PICKER, 2);
		xfer(1'h1, OFS_LINE_CFG, 32'h11);
		chk(line_oe[2], 1, "oe2");
		chk(line_out[2], 1, "out2");
		repeat (4) @(posedge aclk);
		rc(OFS_LEVEL, 1, "readback");
		xfer(1'h1, OFS_PICKER, 0);
		xfer(1'h1, OFS_LINE_CFG, 32'h1);
		chk(line_oe[0], 0, "oe");
		// Glitch 1 us (20 cycles) ahead of bounce 2 us (40 cycles)
		xfer(1'h1, OFS_LINE_CFG, 0);
		xfer(1'h1, OFS_FILTER, 1);
		xfer(1'h1, OFS_LINE_CFG, 32'h10000);
		xfer(1'h1, OFS_FILTER, 2);
		rc(OFS_FILTER, 2, "width");
		ext[0] <= '0;
		repeat (8) @(posedge aclk);
		rc(OFS_LEVEL, 1, "glitch delay");
		repeat (22) @(posedge aclk);
		rc(OFS_LEVEL, 0, "passed");
		ext[0] <= 1'h1;
		// Read after the glitch stage has passed, inside the lockout
		repeat (24) @(posedge aclk);
		rc(OFS_LEVEL, 0, "bounce lock");
		repeat (60) @(posedge aclk);
		rc(OFS_LEVEL, 1, "bounce free");
		ext[0] <= '0;
		repeat (5) @(posedge aclk);
		ext[0] <= 1'h1;
		repeat (25) @(posedge aclk);
		rc(OFS_LEVEL, 1, "short pulse");
		results();
	end
endmodule
`default_nettype wire
